// >>> hw/adc_filter_pkg.sv
// package: register map, fields and constants of the converter control block
package adc_filter_pkg;
  // register byte offsets (chosen, one aligned word each)
  localparam logic [5:0] OFS_CONVERTER_CONFIG = 6'h00;
  localparam logic [5:0] OFS_FILTER_CONFIG    = 6'h04;
  localparam logic [5:0] OFS_FRONTEND_CONTROL = 6'h08;
  localparam logic [5:0] OFS_POWER_BANDWIDTH  = 6'h0c;
  localparam logic [5:0] OFS_TEMP_CHOP        = 6'h10;
  localparam logic [5:0] OFS_RAW_RESULT       = 6'h14;
  localparam logic [5:0] OFS_NOTCH_RESULT     = 6'h18;
  localparam logic [5:0] OFS_TEMP_RESULT      = 6'h1c;
  localparam logic [5:0] OFS_CAL_OFFSET       = 6'h20;
  localparam logic [5:0] OFS_CAL_GAIN         = 6'h24;
  localparam logic [5:0] OFS_TEMP_OFFSET_CAL  = 6'h28;
  localparam logic [5:0] OFS_TEMP_GAIN_CAL    = 6'h2c;

  // reset values
  localparam logic [31:0] RST_FILTER_CONFIG = 32'h0000_0301;
  localparam logic [15:0] RST_GAIN_CAL      = 16'h4000;
  localparam logic [31:0] RST_ZERO          = 32'h0000_0000;

  // field positions
  localparam int POS_MUX_P_LO   = 0;
  localparam int POS_MUX_N_LO   = 8;
  localparam int POS_PGA_GAIN   = 16;
  localparam int POS_S3_RATE16  = 0;
  localparam int POS_NOTCH_OFF  = 4;
  localparam int POS_S3_BYPASS  = 6;
  localparam int POS_OSR_LO     = 8;
  localparam int POS_S3_DEC_LO  = 16;
  localparam int POS_CONV_START = 8;
  localparam int POS_PGA_EN     = 10;
  localparam int POS_TEMP_EN    = 12;
  localparam int POS_TEMP_START = 13;
  localparam int POS_NOTCH_EN   = 16;
  localparam int POS_AAF_LO     = 2;

  // channel codes
  localparam logic [5:0] MUX_P_TEMP    = 6'h0b;
  localparam logic [4:0] MUX_N_TEMP    = 5'h0b;
  localparam logic [4:0] MUX_N_BIASCAP = 5'h08;

  // filter setting codes and sinc2 oversampling
  localparam logic [5:0]  OSR_900SPS  = 6'h03;
  localparam logic [5:0]  OSR_600SPS  = 6'h27;
  localparam logic [5:0]  OSR_300SPS  = 6'h2b;
  localparam logic [10:0] S2_LEN_178  = 11'd178;
  localparam logic [10:0] S2_LEN_667  = 11'd667;
  localparam logic [10:0] S2_LEN_1333 = 11'd1333;

  // sinc3 decimation codes
  localparam logic [1:0] DEC_CODE_2 = 2'h0;
  localparam logic [1:0] DEC_CODE_4 = 2'h1;
  localparam logic [1:0] DEC_CODE_5 = 2'h2;

  localparam logic [15:0] MIDSCALE = 16'h8000;

  // raw sample pacing: 16 MHz conversion clock, 800 kSPS, derived from system clock
  localparam int CLK_SYS_KHZ      = 125000;
  localparam int SAMPLE_RATE_KHZ  = 800;
  localparam int SAMPLE_PERIOD_CY = CLK_SYS_KHZ / SAMPLE_RATE_KHZ;
  localparam int SAMPLE_FAST_CY   = CLK_SYS_KHZ / (2 * SAMPLE_RATE_KHZ);

  typedef struct packed {
    logic        valid;
    logic [15:0] code;
  } sample_type;

  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } bus_req_type;
endpackage

// >>> hw/adc_mux_filter_control.sv
// converter control: mux, gain, calibration, sinc3/sinc2 filters, temperature channel
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
// How it works
// - normal mode paces raw samples at 800 kSPS
// - filter bit 6 low runs sinc3, else bypass
// - sinc3 decimates by 2, 4 or 5
// - notch runs when bit4 clear, enable set
// - notch output readable in notch result register
// - filter code selects sinc2 oversampling length
// - positive mux bits 5:0, negative 12:8
// - gain stage enable and gain field
// - antialias cutoff from bandwidth bits 3:2
// - offset and gain correction always applied, one pair shared by all non-temperature channels
// - temperature channel uses dedicated calibration pair
// - temperature enable bit and channel codes
// - temperature conversion starts on bits 13 and 8
// - raw result is offset binary, 16 bits
// - gain correction always on, not host controlled
// - bypassed filters give raw sample rate
module adc_mux_filter_control
#(
  parameter int FAST_CLK = 0
)
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic [15:0] i_adc_code,
  input  wire logic        i_fast_clock_sel,
  output logic             o_adc_sample,
  output logic [5:0]       o_positive_mux_select,
  output logic [4:0]       o_negative_mux_select,
  output logic             o_pga_enable,
  output logic [2:0]       o_pga_gain,
  output logic [1:0]       o_antialias_cutoff,
  output logic             o_temp_sensor_enable,
  output logic [2:0]       o_temp_chop_mode,
  output logic             o_result_valid
);
  logic [31:0] converter_config_reg;
  logic [31:0] filter_config_reg;
  logic [31:0] frontend_control_reg;
  logic [31:0] power_bandwidth_reg;
  logic [31:0] temp_chop_control;
  logic [15:0] raw_result_reg;
  logic [15:0] notch_result_reg;
  logic [15:0] temp_result_reg;
  logic [15:0] offset_cal_reg;
  logic [15:0] gain_cal_reg;
  logic [15:0] temp_offset_cal_reg;
  logic [15:0] temp_gain_cal_reg;
  logic        bus_done;

  adc_filter_pkg::bus_req_type req;
  assign req = '{address: i_avs_address, read: i_avs_read, write: i_avs_write,
                 writedata: i_avs_writedata};

  function automatic logic [31:0] mapped_read(input logic [5:0] a);
    logic [31:0] r;
    r = '0;
    unique case (a)
      adc_filter_pkg::OFS_CONVERTER_CONFIG: r = converter_config_reg;
      adc_filter_pkg::OFS_FILTER_CONFIG:    r = filter_config_reg;
      adc_filter_pkg::OFS_FRONTEND_CONTROL: r = frontend_control_reg;
      adc_filter_pkg::OFS_POWER_BANDWIDTH:  r = power_bandwidth_reg;
      adc_filter_pkg::OFS_TEMP_CHOP:        r = temp_chop_control;
      adc_filter_pkg::OFS_RAW_RESULT:       r = {16'h0000, raw_result_reg};
      adc_filter_pkg::OFS_NOTCH_RESULT:     r = {16'h0000, notch_result_reg};
      adc_filter_pkg::OFS_TEMP_RESULT:      r = {16'h0000, temp_result_reg};
      adc_filter_pkg::OFS_CAL_OFFSET:       r = {16'h0000, offset_cal_reg};
      adc_filter_pkg::OFS_CAL_GAIN:         r = {16'h0000, gain_cal_reg};
      adc_filter_pkg::OFS_TEMP_OFFSET_CAL:  r = {16'h0000, temp_offset_cal_reg};
      adc_filter_pkg::OFS_TEMP_GAIN_CAL:    r = {16'h0000, temp_gain_cal_reg};
      default:                              r = '0;
    endcase
    return r;
  endfunction

  // bus slave: one wait cycle, then answer; unmapped reads give zero
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= '0;
      bus_done          <= 1'b0;
    end
    else
    begin
      bus_done          <= (req.read | req.write) & ~bus_done & o_avs_waitrequest;
      o_avs_waitrequest <= ~((req.read | req.write) & ~bus_done & o_avs_waitrequest);
      if (req.read)
      begin
        o_avs_readdata <= mapped_read(req.address);
      end
    end
  end

  wire logic wr_take = req.write & ~o_avs_waitrequest;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      converter_config_reg <= adc_filter_pkg::RST_ZERO;
      filter_config_reg    <= adc_filter_pkg::RST_FILTER_CONFIG;
      frontend_control_reg <= adc_filter_pkg::RST_ZERO;
      power_bandwidth_reg  <= adc_filter_pkg::RST_ZERO;
      temp_chop_control    <= adc_filter_pkg::RST_ZERO;
      offset_cal_reg       <= '0;
      gain_cal_reg         <= adc_filter_pkg::RST_GAIN_CAL;
      temp_offset_cal_reg  <= '0;
      temp_gain_cal_reg    <= adc_filter_pkg::RST_GAIN_CAL;
    end
    else if (wr_take)
    begin
      unique case (req.address)
        adc_filter_pkg::OFS_CONVERTER_CONFIG: converter_config_reg <= req.writedata;
        adc_filter_pkg::OFS_FILTER_CONFIG:    filter_config_reg    <= req.writedata;
        adc_filter_pkg::OFS_FRONTEND_CONTROL: frontend_control_reg <= req.writedata;
        adc_filter_pkg::OFS_POWER_BANDWIDTH:  power_bandwidth_reg  <= req.writedata;
        adc_filter_pkg::OFS_TEMP_CHOP:        temp_chop_control    <= req.writedata;
        adc_filter_pkg::OFS_CAL_OFFSET:       offset_cal_reg       <= req.writedata[15:0];
        adc_filter_pkg::OFS_CAL_GAIN:         gain_cal_reg         <= req.writedata[15:0];
        adc_filter_pkg::OFS_TEMP_OFFSET_CAL:  temp_offset_cal_reg  <= req.writedata[15:0];
        adc_filter_pkg::OFS_TEMP_GAIN_CAL:    temp_gain_cal_reg    <= req.writedata[15:0];
        default:                              ;
      endcase
    end
  end

  // analog control outputs
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_positive_mux_select <= '0;
      o_negative_mux_select <= '0;
      o_pga_enable          <= 1'b0;
      o_pga_gain            <= '0;
      o_antialias_cutoff    <= '0;
      o_temp_sensor_enable  <= 1'b0;
      o_temp_chop_mode      <= '0;
    end
    else
    begin
      o_positive_mux_select <= converter_config_reg[adc_filter_pkg::POS_MUX_P_LO +: 6];
      o_negative_mux_select <= converter_config_reg[adc_filter_pkg::POS_MUX_N_LO +: 5];
      o_pga_enable          <= frontend_control_reg[adc_filter_pkg::POS_PGA_EN];
      o_pga_gain            <= converter_config_reg[adc_filter_pkg::POS_PGA_GAIN +: 3];
      o_antialias_cutoff    <= power_bandwidth_reg[adc_filter_pkg::POS_AAF_LO +: 2];
      o_temp_sensor_enable  <= frontend_control_reg[adc_filter_pkg::POS_TEMP_EN];
      o_temp_chop_mode      <= temp_chop_control[3:1];
    end
  end

  // sample pacing; fast clock halves the period
  localparam int PW = 8;
  logic [PW-1:0] pace_cnt;
  logic          conv_run;
  wire logic [PW-1:0] pace_top = i_fast_clock_sel ?
    PW'(adc_filter_pkg::SAMPLE_FAST_CY - 1) : PW'(adc_filter_pkg::SAMPLE_PERIOD_CY - 1);
  // conversion runs while start bit (and temp start for temp channel) set
  wire logic temp_chan =
    converter_config_reg[adc_filter_pkg::POS_MUX_P_LO +: 6] == adc_filter_pkg::MUX_P_TEMP;
  assign conv_run = frontend_control_reg[adc_filter_pkg::POS_CONV_START] &
    (~temp_chan | frontend_control_reg[adc_filter_pkg::POS_TEMP_START]);

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      pace_cnt     <= '0;
      o_adc_sample <= 1'b0;
    end
    else
    begin
      o_adc_sample <= conv_run && pace_cnt == pace_top;
      pace_cnt     <= (!conv_run || pace_cnt >= pace_top) ? '0 : pace_cnt + 1'b1;
    end
  end

  // correction: (code - mid - offset) * gain / 0x4000 + mid
  function automatic logic [15:0] correct(input logic [15:0] code,
                                          input logic [15:0] ofs,
                                          input logic [15:0] gn);
    logic signed [17:0] centred;
    logic signed [35:0] prod;
    logic signed [35:0] shifted;
    centred = $signed({2'b00, code}) - 18'sd32768 - $signed({{2{ofs[15]}}, ofs});
    prod    = centred * $signed({2'b00, gn});
    shifted = prod >>> 14;
    if (shifted > 36'sd32767)
      correct = 16'hffff;
    else if (shifted < -36'sd32768)
      correct = 16'h0000;
    else
      correct = 16'(shifted[15:0] ^ adc_filter_pkg::MIDSCALE);
  endfunction

  // temperature channel picks its own calibration pair
  // gain correction has no disable path
  adc_filter_pkg::sample_type cal;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      cal <= '0;
    else
    begin
      cal.valid <= o_adc_sample;
      if (o_adc_sample)
        cal.code <= temp_chan ? correct(i_adc_code, temp_offset_cal_reg, temp_gain_cal_reg)
                              : correct(i_adc_code, offset_cal_reg, gain_cal_reg);
    end
  end

  logic [2:0] s3_ratio;
  always_comb
  begin
    unique case (filter_config_reg[adc_filter_pkg::POS_S3_DEC_LO +: 2])
      adc_filter_pkg::DEC_CODE_2: s3_ratio = 3'd2;
      adc_filter_pkg::DEC_CODE_5: s3_ratio = 3'd5;
      default:                    s3_ratio = 3'd4;
    endcase
  end

  // sinc3: three integrators, decimate, three combs
  logic signed [31:0] i1, i2, i3, c1, c2, c3, d1, d2, d3;
  logic [2:0]         s3_cnt;
  adc_filter_pkg::sample_type s3;
  wire logic s3_bypass = filter_config_reg[adc_filter_pkg::POS_S3_BYPASS];
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      {i1, i2, i3, d1, d2, d3} <= '0;
      s3_cnt <= '0;
      s3     <= '0;
    end
    else
    begin
      s3.valid <= 1'b0;
      if (cal.valid)
      begin
        if (s3_bypass)
        begin
          s3.valid <= 1'b1;
          s3.code  <= cal.code;
        end
        else
        begin
          i1 <= i1 + $signed({16'h0000, cal.code});
          i2 <= i2 + i1;
          i3 <= i3 + i2;
          s3_cnt <= (s3_cnt >= s3_ratio - 3'd1) ? '0 : s3_cnt + 3'd1;
          if (s3_cnt >= s3_ratio - 3'd1)
          begin
            d1 <= i3;
            d2 <= c1;
            d3 <= c2;
            s3.valid <= 1'b1;
            s3.code  <= 16'(c3 / (32'(s3_ratio) * 32'(s3_ratio) * 32'(s3_ratio)));
          end
        end
      end
    end
  end
  assign c1 = i3 - d1;
  assign c2 = c1 - d2;
  assign c3 = c2 - d3;

  logic [10:0] s2_len;
  always_comb
  begin
    unique case (filter_config_reg[adc_filter_pkg::POS_OSR_LO +: 6])
      adc_filter_pkg::OSR_600SPS: s2_len = adc_filter_pkg::S2_LEN_667;
      adc_filter_pkg::OSR_300SPS: s2_len = adc_filter_pkg::S2_LEN_1333;
      default:                    s2_len = adc_filter_pkg::S2_LEN_178;
    endcase
  end

  wire logic notch_on = ~filter_config_reg[adc_filter_pkg::POS_NOTCH_OFF] &
                        frontend_control_reg[adc_filter_pkg::POS_NOTCH_EN];
  logic [31:0] n_acc, n_acc2;
  logic [10:0] n_cnt;
  logic        n_phase;
  logic        notch_valid;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || !notch_on)
    begin
      n_acc <= '0;
      n_acc2 <= '0;
      n_cnt <= '0;
      n_phase <= 1'b0;
      notch_valid <= 1'b0;
      notch_result_reg <= '0;
    end
    else
    begin
      notch_valid <= 1'b0;
      if (s3.valid)
      begin
        // sinc2 as one mean over two consecutive blocks of s2_len samples
        if (n_cnt == s2_len - 11'd1)
        begin
          n_cnt <= '0;
          n_phase <= ~n_phase;
          n_acc <= '0;
          n_acc2 <= n_acc + 32'(s3.code);
          if (n_phase)
          begin
            // notch output into its result register
            notch_valid <= 1'b1;
            notch_result_reg <= 16'((n_acc2 + n_acc + 32'(s3.code)) / (32'(s2_len) * 2));
          end
        end
        else
        begin
          n_cnt <= n_cnt + 11'd1;
          n_acc <= n_acc + 32'(s3.code);
        end
      end
    end
  end

  // offset binary result registers update only on strobes
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      raw_result_reg  <= '0;
      temp_result_reg <= '0;
      o_result_valid  <= 1'b0;
    end
    else
    begin
      o_result_valid <= s3.valid;
      if (s3.valid)
        raw_result_reg <= s3.code;
      // temperature channel needs both mux codes
      if (s3.valid && temp_chan && o_negative_mux_select == adc_filter_pkg::MUX_N_TEMP)
        temp_result_reg <= s3.code;
    end
  end

  // bypass gives a strobe one cycle after each calibrated sample
  a_bypass_follow: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    cal.valid && s3_bypass && $stable(s3_bypass) |=> s3.valid) else $error("bypass lost sample");
  a_strobe_single: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_adc_sample |=> !o_adc_sample) else $error("sample strobe too long");
  a_notch_idle: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !notch_on |=> !notch_valid) else $error("notch active while off");
  a_start_gate: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !conv_run ##1 !conv_run |=> !o_adc_sample) else $error("sample without start");
  a_temp_cal: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_adc_sample && temp_chan |=>
    cal.code == correct($past(i_adc_code), $past(temp_offset_cal_reg),
                        $past(temp_gain_cal_reg)))
    else $error("wrong calibration pair");
  a_raw_update: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    s3.valid |=> raw_result_reg == $past(s3.code)) else $error("raw result stale");
  a_mux_track: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    ##1 o_positive_mux_select == $past(converter_config_reg[5:0])) else $error("mux mismatch");
  a_pga_track: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    ##1 o_pga_enable == $past(frontend_control_reg[10])) else $error("gain enable mismatch");
endmodule

// >>> bench/adc_converter_model.sv
// converter model: hands offset-binary codes to the control block on request
`timescale 1ns/100ps
module adc_converter_model
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_adc_sample,
  input  wire logic [15:0] i_level,
  output logic [15:0]      o_adc_code
);
  logic [15:0] last;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_adc_sample)
      last <= i_level;
  end

  // offset binary code, midscale is zero input
  // code valid only in the cycle the conversion is requested
  // outside the request the bus shows the inverse, so a late capture is caught
  always_comb
  begin
    o_adc_code = i_adc_sample ? i_level : ~last;
  end
endmodule

// >>> bench/adc_mux_filter_control_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module adc_mux_filter_control_tb;
  typedef struct {
    logic [5:0]  addr;
    logic [31:0] rst;
    logic [31:0] wr;
    logic [31:0] rd;
  } row_type;

  logic        i_clk_sys;
  logic        i_reset;
  logic [5:0]  i_avs_address;
  logic        i_avs_read;
  logic        i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic [15:0] i_adc_code;
  logic        i_fast_clock_sel;
  logic        o_adc_sample;
  logic [5:0]  o_positive_mux_select;
  logic [4:0]  o_negative_mux_select;
  logic        o_pga_enable;
  logic [2:0]  o_pga_gain;
  logic [1:0]  o_antialias_cutoff;
  logic        o_temp_sensor_enable;
  logic [2:0]  o_temp_chop_mode;
  logic        o_result_valid;
  logic [15:0] level;
  logic [31:0] q;
  int          mismatches;
  int          samples_checked;
  int          n;
  int          cnt;
  int          strobes = 0;
  int          ratio[3] = '{2, 4, 5};
  row_type     rows[12] = '{
    '{6'h00, 32'h0, 32'h0004_0805, 32'h0004_0805},
    '{6'h04, 32'h301, 32'h0000_0351, 32'h0000_0351},
    '{6'h08, 32'h0, 32'h0000_1500, 32'h0000_1500},
    '{6'h0c, 32'h0, 32'h0000_000c, 32'h0000_000c},
    '{6'h10, 32'h0, 32'h0000_000a, 32'h0000_000a},
    '{6'h18, 32'h0, 32'h0000_ffff, 32'h0},
    '{6'h1c, 32'h0, 32'h0000_ffff, 32'h0},
    '{6'h20, 32'h0, 32'h0, 32'h0},
    '{6'h24, 32'h4000, 32'h4000, 32'h4000},
    '{6'h28, 32'h0, 32'h0, 32'h0},
    '{6'h2c, 32'h4000, 32'h2000, 32'h2000},
    '{6'h30, 32'h0, 32'h0000_dead, 32'h0}};

  initial i_clk_sys = 1'b0;
  always #4 i_clk_sys = ~i_clk_sys;

  adc_mux_filter_control u_dut (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_adc_code(i_adc_code), .i_fast_clock_sel(i_fast_clock_sel),
    .o_adc_sample(o_adc_sample), .o_positive_mux_select(o_positive_mux_select),
    .o_negative_mux_select(o_negative_mux_select), .o_pga_enable(o_pga_enable),
    .o_pga_gain(o_pga_gain), .o_antialias_cutoff(o_antialias_cutoff),
    .o_temp_sensor_enable(o_temp_sensor_enable), .o_temp_chop_mode(o_temp_chop_mode),
    .o_result_valid(o_result_valid));

  adc_converter_model u_conv (
    .i_clk_sys(i_clk_sys), .i_adc_sample(o_adc_sample), .i_level(level),
    .o_adc_code(i_adc_code));

  task automatic print_verdict();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic timed_out();
    mismatches++;
    $display("MISMATCH wait expected answer seen none");
    print_verdict();
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  // one transfer; entered right after a rising edge, held until waitrequest low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int t;
    t = 0;
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    @(posedge i_clk_sys);
    while (o_avs_waitrequest !== 1'b0 && t < 100)
    begin
      @(posedge i_clk_sys);
      t++;
    end
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(posedge i_clk_sys);
    if (t >= 100)
      timed_out();
  endtask

  function automatic logic pick(input bit vld);
    return vld ? o_result_valid : o_adc_sample;
  endfunction

  // cycles between two pulses of the chosen strobe
  task automatic gap(input bit vld, output int p);
    int t;
    t = 0;
    while (pick(vld) !== 1'b1 && t < 2000)
    begin
      @(posedge i_clk_sys);
      t++;
    end
    @(posedge i_clk_sys);
    `CHK("strobe width", 1'b0, pick(vld))
    p = 1;
    while (pick(vld) !== 1'b1 && p < 2000)
    begin
      @(posedge i_clk_sys);
      p++;
    end
    if (t >= 2000 || p >= 2000)
      timed_out();
  endtask

  // result strobes counted from outside, so filter lengths can be measured
  always @(posedge i_clk_sys)
  begin
    if (o_result_valid === 1'b1)
      strobes <= strobes + 1;
  end

  initial
  begin
    repeat (100000) @(posedge i_clk_sys);
    timed_out();
  end

  initial
  begin
    i_reset = 1'b1;
    i_avs_address = 6'h00;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h0;
    i_fast_clock_sel = 1'b0;
    level = 16'h9234;
    repeat (3) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    @(posedge i_clk_sys);
    foreach (rows[i])
    begin
      bus(1'b0, rows[i].addr, 32'h0, q);
      `CHK("reset value", rows[i].rst, q)
    end
    done("reset values");
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].addr, rows[i].wr, q);
      bus(1'b0, rows[i].addr, 32'h0, q);
      `CHK("readback", rows[i].rd, q)
    end
    `CHK("positive mux", 6'h05, o_positive_mux_select)
    `CHK("negative mux", adc_filter_pkg::MUX_N_BIASCAP, o_negative_mux_select)
    `CHK("gain field", 3'h4, o_pga_gain)
    `CHK("gain enable", 1'b1, o_pga_enable)
    `CHK("antialias", 2'h3, o_antialias_cutoff)
    `CHK("temp enable", 1'b1, o_temp_sensor_enable)
    `CHK("chop mode", 3'h5, o_temp_chop_mode)
    done("register table");
    gap(1'b0, n);
    `CHK("sample period", adc_filter_pkg::SAMPLE_PERIOD_CY, n)
    gap(1'b1, n);
    `CHK("bypass rate", adc_filter_pkg::SAMPLE_PERIOD_CY, n)
    bus(1'b0, adc_filter_pkg::OFS_RAW_RESULT, 32'h0, q);
    `CHK("raw result", 32'h0000_9234, q)
    done("bypass path");
    bus(1'b1, adc_filter_pkg::OFS_CONVERTER_CONFIG, 32'h0000_0b0b, q);
    repeat (200) @(posedge i_clk_sys);
    cnt = 0;
    repeat (400)
    begin
      @(posedge i_clk_sys);
      if (o_adc_sample === 1'b1)
        cnt++;
    end
    `CHK("temp without start", 0, cnt)
    bus(1'b1, adc_filter_pkg::OFS_FRONTEND_CONTROL, 32'h0000_3500, q);
    gap(1'b1, n);
    gap(1'b1, n);
    bus(1'b0, adc_filter_pkg::OFS_RAW_RESULT, 32'h0, q);
    `CHK("temp calibrated", 32'h0000_891a, q)
    bus(1'b0, adc_filter_pkg::OFS_TEMP_RESULT, 32'h0, q);
    `CHK("temp result", 32'h0000_891a, q)
    done("temperature channel");
    bus(1'b1, adc_filter_pkg::OFS_CONVERTER_CONFIG, 32'h0004_0805, q);
    bus(1'b1, adc_filter_pkg::OFS_FRONTEND_CONTROL, 32'h0000_1500, q);
    for (int d = 0; d < 3; d++)
    begin
      bus(1'b1, adc_filter_pkg::OFS_FILTER_CONFIG, 32'h0000_0311 | (32'(d) << 16), q);
      gap(1'b1, n);
      gap(1'b1, n);
      `CHK("sinc3 period", ratio[d] * adc_filter_pkg::SAMPLE_PERIOD_CY, n)
    end
    // one more word so the last three comb intervals all use ratio 5
    gap(1'b1, n);
    bus(1'b0, adc_filter_pkg::OFS_RAW_RESULT, 32'h0, q);
    `CHK("sinc3 value", 32'h0000_9234, q)
    done("sinc3 ratios");
    i_fast_clock_sel <= 1'b1;
    // host clears filter bit 0 for the fast rate
    bus(1'b1, adc_filter_pkg::OFS_FILTER_CONFIG, 32'h0000_0350, q);
    gap(1'b0, n);
    gap(1'b0, n);
    `CHK("fast period", adc_filter_pkg::SAMPLE_FAST_CY, n)
    done("fast clock");
    // notch on: bit 4 clear, front-end enable set, shortest filter code
    bus(1'b1, adc_filter_pkg::OFS_FILTER_CONFIG, 32'h0000_0340, q);
    bus(1'b1, adc_filter_pkg::OFS_FRONTEND_CONTROL, 32'h0001_1500, q);
    n = strobes;
    cnt = 0;
    q = 32'h0;
    while (q === 32'h0 && cnt < 12000)
    begin
      bus(1'b0, adc_filter_pkg::OFS_NOTCH_RESULT, 32'h0, q);
      cnt++;
    end
    if (cnt >= 12000)
      timed_out();
    `CHK("notch result", 32'h0000_9234, q)
    `CHK("notch length", adc_filter_pkg::S2_LEN_178, (strobes - n) / 2)
    // longer code: no new word within 400 strobes although the level moves
    bus(1'b1, adc_filter_pkg::OFS_FILTER_CONFIG, 32'h0000_2740, q);
    level <= 16'h8000;
    n = strobes;
    cnt = 0;
    while (strobes - n < 400 && cnt < 40000)
    begin
      @(posedge i_clk_sys);
      cnt++;
    end
    if (cnt >= 40000)
      timed_out();
    bus(1'b0, adc_filter_pkg::OFS_NOTCH_RESULT, 32'h0, q);
    `CHK("notch long code", 32'h0000_9234, q)
    done("notch filter");
    i_reset <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    @(posedge i_clk_sys);
    `CHK("reset sample", 1'b0, o_adc_sample)
    bus(1'b0, adc_filter_pkg::OFS_FILTER_CONFIG, 32'h0, q);
    `CHK("reset filter", adc_filter_pkg::RST_FILTER_CONFIG, q)
    bus(1'b0, adc_filter_pkg::OFS_NOTCH_RESULT, 32'h0, q);
    `CHK("reset notch", 32'h0, q)
    done("mid-run reset");
    print_verdict();
  end
endmodule
